// ---- design/cot_carrier_timer.sv ----
// Purpose: Carrier/NRZ output shaping and two 8-bit interval timers
// Assumes: Byte writes and reads on the internal memory bus, one per cycle
// Notes:   The doubled clock choice of timer B runs at fx; cascade and PWM are not built
`include "cot_defines.svh"
`timescale 1ns/1ps
module cot_carrier_timer (
	input  wire logic        ref_clk,         // System clock fx
	input  wire logic        reset,           // Synchronous reset, high
	input  wire logic        clk_en,          // Freezes all state when low
	input  wire logic [15:0] mem_addr,        // Memory bus address
	input  wire logic [7:0]  mem_wdata,       // Write data
	input  wire logic        mem_wr,          // Byte write strobe
	input  wire logic        mem_rd,          // Byte read strobe
	output logic      [7:0]  mem_rdata,       // Read data, valid one cycle after mem_rd
	output logic             timer_output_pin,// Shaped timer output
	output logic      [7:0]  port2_oe_n,      // Port 2 output buffers, low drives
	output logic             irq_match_a,     // Timer A match request pulse
	output logic             irq_match_b      // Timer B match request pulse
);
	// Software-visible registers
	logic [7:0] port2_direction;       // Port 2 direction
	logic [7:0] timer_a_mode_control;  // Timer A mode
	logic [7:0] timer_b_mode_control;  // Timer B mode
	logic [7:0] compare_value_a;       // Timer A compare
	logic [7:0] compare_value_b;       // Timer B compare
	logic       timer_a_clock_extra_bit; // Timer A clock extension
	logic       remote_output_select;  // Steady high instead of carrier
	logic       nrz_next_buffer;       // Next NRZ value
	logic       nrz_active_bit;        // Active NRZ value
	logic       output_invert_bit;     // Invert timer output

	// Internal state
	logic [`COT_PRESC_W-1:0] presc;    // Free prescaler
	logic       carrier;               // Carrier clock from timer B
	logic       square;                // Discrete-mode square wave
	logic [7:0] count_a;               // Timer A counter
	logic [7:0] count_b;               // Timer B counter
	logic       match_a;               // Timer A match pulse
	logic       match_b;               // Timer B match pulse
	logic       tick_a;                // Timer A count clock
	logic       tick_b;                // Timer B count clock
	logic       next_pin;              // Next timer pin level
	logic       shaped;                // Waveform before inversion

	// Decoded controls
	cot_pkg::cot_mode_t  mode;
	cot_pkg::cot_a_clk_t sel_a;
	logic                wr_en;
	logic                toe_b;
	logic                carrier_mode;
	assign wr_en        = mem_wr && clk_en;
	assign toe_b        = timer_b_mode_control[`COT_BIT_TOE];
	assign mode         = cot_pkg::cot_mode_t'({timer_a_mode_control[`COT_MODE_HI:`COT_MODE_LO],
	                                            timer_b_mode_control[`COT_MODE_HI:`COT_MODE_LO]});
	assign carrier_mode = (mode == cot_pkg::COT_MODE_CARRIER);
	assign sel_a        = cot_pkg::cot_a_clk_t'(timer_a_mode_control[`COT_SEL_HI:`COT_SEL_LO]);

	// Tap of the prescaler: true once every 2^n cycles
	function automatic logic tap(input logic [`COT_PRESC_W-1:0] p, input int n);
		logic hit;
		hit = 1'b1;
		for (int i = 0; i < `COT_PRESC_W; i++) begin
			if (i < n) begin
				hit = hit & p[i];
			end
		end
		return hit;
	endfunction

	// Prescaler runs free so every tap stays phase-aligned
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			presc <= '0;
		end else if (clk_en) begin
			presc <= presc + 1'b1;
		end
	end

	// Timer A count clock choice
	always_comb begin
		unique case (sel_a)
			cot_pkg::COT_CLK_DIV64:   tick_a = tap(presc, `COT_TAP_64);
			cot_pkg::COT_CLK_DIV256:  tick_a = tap(presc, `COT_TAP_256);
			cot_pkg::COT_CLK_DIV16:   tick_a = tap(presc, `COT_TAP_16);
			cot_pkg::COT_CLK_DIVEXT:  tick_a = timer_a_clock_extra_bit ? tap(presc, `COT_TAP_4K)
			                                                           : tap(presc, `COT_TAP_1K);
			cot_pkg::COT_CLK_BMATCH:  tick_a = match_b;
			cot_pkg::COT_CLK_CARRIER: tick_a = match_b && !carrier;
			default:                  tick_a = 1'b0; // Prohibited codes hold the count
		endcase
	end

	// Timer B count clock choice; the doubled rate falls back to fx
	always_comb begin
		unique case (timer_b_mode_control[`COT_SEL_HI:`COT_SEL_LO])
			3'h0, 3'h1: tick_b = 1'b1;
			3'h2:       tick_b = tap(presc, `COT_TAP_2);
			3'h3:       tick_b = tap(presc, `COT_TAP_4);
			3'h4:       tick_b = tap(presc, `COT_TAP_8);
			3'h5:       tick_b = tap(presc, `COT_TAP_16);
			default:    tick_b = 1'b0;
		endcase
	end

	// The two independent interval counters
	cot_counter8 #(.WIDTH(8)) u_count_a (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clk_en  (clk_en),
		.run     (timer_a_mode_control[`COT_BIT_RUN]),
		.tick    (tick_a),
		.compare (compare_value_a),
		.count   (count_a),
		.match   (match_a)
	);
	cot_counter8 #(.WIDTH(8)) u_count_b (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clk_en  (clk_en),
		.run     (timer_b_mode_control[`COT_BIT_RUN]),
		.tick    (tick_b),
		.compare (compare_value_b),
		.count   (count_b),
		.match   (match_b)
	);

	// Plain control registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			port2_direction         <= `COT_RST_PORT2_DIR;
			timer_a_mode_control    <= `COT_RST_ZERO;
			timer_b_mode_control    <= `COT_RST_ZERO;
			compare_value_a         <= `COT_RST_ZERO;
			compare_value_b         <= `COT_RST_ZERO;
			timer_a_clock_extra_bit <= 1'b0;
			output_invert_bit       <= 1'b0;
		end else if (wr_en) begin
			unique case (mem_addr)
				`COT_ADDR_PORT2_DIR:    port2_direction <= mem_wdata;
				`COT_ADDR_MODE_A:       timer_a_mode_control <= mem_wdata;
				`COT_ADDR_MODE_B:       timer_b_mode_control <= mem_wdata;
				`COT_ADDR_COMPARE_A:    compare_value_a <= mem_wdata;
				`COT_ADDR_COMPARE_B:    compare_value_b <= mem_wdata;
				`COT_ADDR_CLOCK_EXT_A:  timer_a_clock_extra_bit <= mem_wdata[0];
				`COT_ADDR_INVERT_CTRL:  output_invert_bit <= mem_wdata[0];
				default: ;
			endcase
		end
	end

	// Remote select and NRZ buffer
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			remote_output_select <= 1'b0;
			nrz_next_buffer      <= 1'b0;
		end else if (wr_en && mem_addr == `COT_ADDR_CARRIER_CTRL) begin
			remote_output_select <= mem_wdata[`COT_BIT_REMOTE];
			nrz_next_buffer      <= mem_wdata[`COT_BIT_NRZ_BUF];
		end
	end

	// Active NRZ: a timer A match wins over a same-cycle software write
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			nrz_active_bit <= 1'b0;
		end else if (clk_en) begin
			if (match_a) begin
				nrz_active_bit <= nrz_next_buffer;
			end else if (wr_en && mem_addr == `COT_ADDR_CARRIER_CTRL && !toe_b) begin
				nrz_active_bit <= mem_wdata[`COT_BIT_NRZ];
			end
		end
	end

	// Carrier toggles on each timer B match in carrier mode, cleared when stopped
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			carrier <= 1'b0;
			square  <= 1'b0;
		end else if (clk_en) begin
			if (!timer_b_mode_control[`COT_BIT_RUN]) begin
				carrier <= 1'b0;
				square  <= 1'b0;
			end else if (match_b) begin
				carrier <= carrier_mode ? !carrier : 1'b0;
				square  <= (mode == cot_pkg::COT_MODE_DISCRETE && toe_b) ? !square : 1'b0;
			end
		end
	end

	// Waveform selection, then inversion, then output gating
	always_comb begin
		if (!carrier_mode) begin
			shaped = square;
		end else if (!nrz_active_bit) begin
			shaped = 1'b0;
		end else if (remote_output_select) begin
			shaped = 1'b1;
		end else begin
			shaped = carrier;
		end
		next_pin = toe_b && (shaped ^ output_invert_bit);
	end

	// Registered pin, buffer enables and match requests
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			timer_output_pin <= 1'b0;
			port2_oe_n       <= `COT_RST_PORT2_DIR;
			irq_match_a      <= 1'b0;
			irq_match_b      <= 1'b0;
		end else if (clk_en) begin
			timer_output_pin <= next_pin;
			port2_oe_n       <= port2_direction;
			irq_match_a      <= match_a;
			irq_match_b      <= match_b;
		end
	end

	// Read port; the active NRZ bit is write-only and reads zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mem_rdata <= `COT_RST_ZERO;
		end else if (clk_en && mem_rd) begin
			unique case (mem_addr)
				`COT_ADDR_PORT2_DIR:    mem_rdata <= port2_direction;
				`COT_ADDR_MODE_A:       mem_rdata <= timer_a_mode_control;
				`COT_ADDR_MODE_B:       mem_rdata <= timer_b_mode_control;
				`COT_ADDR_COMPARE_A:    mem_rdata <= compare_value_a;
				`COT_ADDR_COMPARE_B:    mem_rdata <= compare_value_b;
				`COT_ADDR_COUNT_A:      mem_rdata <= count_a;
				`COT_ADDR_COUNT_B:      mem_rdata <= count_b;
				`COT_ADDR_CLOCK_EXT_A:  mem_rdata <= {7'h00, timer_a_clock_extra_bit};
				`COT_ADDR_CARRIER_CTRL: mem_rdata <= {5'h00, remote_output_select, nrz_next_buffer, 1'b0};
				`COT_ADDR_INVERT_CTRL:  mem_rdata <= {7'h00, output_invert_bit};
				default:                mem_rdata <= `COT_RST_ZERO;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	nrz_low_pin_a: assert property (
		clk_en && carrier_mode && !nrz_active_bit ##1 clk_en
		|-> timer_output_pin == ($past(output_invert_bit) && $past(toe_b)))
		else $error("NRZ low did not force low");
	remote_high_a: assert property (
		clk_en && carrier_mode && nrz_active_bit && remote_output_select && toe_b && !output_invert_bit
		|=> timer_output_pin)
		else $error("Remote select high lost");
	carrier_pass_a: assert property (
		clk_en && carrier_mode && nrz_active_bit && !remote_output_select && toe_b && !output_invert_bit
		|=> timer_output_pin == $past(carrier))
		else $error("Carrier not passed");
	nrz_copy_a: assert property (
		clk_en && match_a |=> nrz_active_bit == $past(nrz_next_buffer))
		else $error("NRZ buffer not copied");
	nrz_guard_a: assert property (
		clk_en && toe_b && !match_a |=> $stable(nrz_active_bit))
		else $error("NRZ written while output enabled");
	match_clear_a: assert property (
		clk_en && match_b |-> count_b == 8'h00)
		else $error("Counter not cleared on match");
	irq_follow_a: assert property (
		clk_en && match_a |=> irq_match_a)
		else $error("Match request missing");
	pin_gate_a: assert property (
		clk_en && !toe_b |=> !timer_output_pin)
		else $error("Pin driven while disabled");
	invert_path_a: assert property (
		clk_en && toe_b |=> timer_output_pin == ($past(shaped) ^ $past(output_invert_bit)))
		else $error("Inversion wrong");
	// Counting timer B matches: without a match the timer A count must hold
	bmatch_tick_a: assert property (
		clk_en && !wr_en && sel_a == cot_pkg::COT_CLK_BMATCH && timer_a_mode_control[`COT_BIT_RUN] && !match_b
		|=> $stable(count_a))
		else $error("Timer A moved without timer B match");
	dir_follow_a: assert property (
		clk_en ##1 clk_en |-> port2_oe_n == $past(port2_direction))
		else $error("Direction not applied");

	carrier_out_c: cover property (carrier_mode && nrz_active_bit && timer_output_pin);
	nrz_swap_c: cover property (match_a && nrz_next_buffer != nrz_active_bit);
	interval_b_c: cover property (irq_match_b ##[1:20] irq_match_b);
endmodule

// ---- design/cot_counter8.sv ----
// Purpose: One interval counter with compare-match clear
// Assumes: Tick is a one-cycle enable on ref_clk
// Notes:   Interval is (compare+1) ticks; stopped counter holds zero
`timescale 1ns/1ps
module cot_counter8 #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,  // System clock
	input  wire logic             reset,    // Synchronous reset, high
	input  wire logic             clk_en,   // Freezes state when low
	input  wire logic             run,      // Count enable
	input  wire logic             tick,     // Count clock pulse
	input  wire logic [WIDTH-1:0] compare,  // Compare value
	output logic      [WIDTH-1:0] count,    // Counter value
	output logic                  match     // One-cycle match pulse
);
	// Counter; stopping clears it so a restart begins from zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count <= '0;
		end else if (clk_en) begin
			if (!run) begin
				count <= '0;
			end else if (tick && count == compare) begin
				count <= '0;
			end else if (tick) begin
				count <= count + 1'b1;
			end
		end
	end

	// Match pulse raised with the clearing tick
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			match <= 1'b0;
		end else if (clk_en) begin
			match <= run && tick && count == compare;
		end
	end
endmodule

// ---- inc/cot_defines.svh ----
// Purpose: Addresses, field positions, reset values and clock taps of the carrier/interval timer block
// Assumes: Byte-wide internal memory bus with 16-bit addresses
// Notes:   Included by bare name; definitions only
`ifndef COT_DEFINES_SVH
`define COT_DEFINES_SVH

// Register addresses
`define COT_ADDR_PORT2_DIR      16'hff22
`define COT_ADDR_COUNT_A        16'hff62
`define COT_ADDR_COUNT_B        16'hff63
`define COT_ADDR_COMPARE_A      16'hff64
`define COT_ADDR_COMPARE_B      16'hff65
`define COT_ADDR_MODE_A         16'hff68
`define COT_ADDR_MODE_B         16'hff69
`define COT_ADDR_CARRIER_CTRL   16'hff6a
`define COT_ADDR_INVERT_CTRL    16'hff6b
`define COT_ADDR_CLOCK_EXT_A    16'hff6d

// Reset values
`define COT_RST_PORT2_DIR       8'hff
`define COT_RST_ZERO            8'h00

// Mode control fields (both timers)
`define COT_BIT_RUN             7
`define COT_SEL_HI              5
`define COT_SEL_LO              3
`define COT_MODE_HI             2
`define COT_MODE_LO             1
`define COT_BIT_TOE             0

// Carrier output control fields
`define COT_BIT_REMOTE          2
`define COT_BIT_NRZ_BUF         1
`define COT_BIT_NRZ             0

// Shared pin position inside port 2
`define COT_SHARED_PIN          3

// Prescaler taps (powers of two of fx)
`define COT_TAP_2               1
`define COT_TAP_4               2
`define COT_TAP_8               3
`define COT_TAP_16              4
`define COT_TAP_64              6
`define COT_TAP_256             8
`define COT_TAP_1K              10
`define COT_TAP_4K              12
`define COT_PRESC_W             12

`endif

// ---- inc/cot_pkg.sv ----
// Purpose: Types shared by the carrier/interval timer block
// Assumes: Nothing beyond SystemVerilog
// Notes:   Holds types only; numbers live in the defines header
package cot_pkg;
	// Combined mode code {A1,A0,B1,B0}
	typedef enum logic [3:0] {
		COT_MODE_DISCRETE = 4'h0,
		COT_MODE_PWM      = 4'h2,
		COT_MODE_CARRIER  = 4'h3,
		COT_MODE_CASCADE  = 4'h5
	} cot_mode_t;

	// Timer A count clock choices
	typedef enum logic [2:0] {
		COT_CLK_DIV64   = 3'h0,
		COT_CLK_DIV256  = 3'h1,
		COT_CLK_DIV16   = 3'h2,
		COT_CLK_DIVEXT  = 3'h3,
		COT_CLK_BMATCH  = 3'h4,
		COT_CLK_CARRIER = 3'h5
	} cot_a_clk_t;
endpackage

// ---- test/cot_pin_watch.sv ----
// Purpose: Far-side receiver that watches the shaped timer output
// Assumes: Pin is sampled on ref_clk like a synchronous receiver
// Notes:   Counts level changes only; it never drives the pin
`timescale 1ns/1ps
module cot_pin_watch (
	input  wire logic ref_clk, // System clock
	input  wire logic pin,     // Timer output as seen by the receiver
	input  wire logic clear,   // Restarts the edge count
	output int        edges    // Level changes seen since clear
);
	logic last; // Pin level one cycle ago

	// Edge counter; a receiver only sees transitions, not levels
	always_ff @(posedge ref_clk) begin
		last <= pin;
		if (clear) begin
			edges <= 0;
		end else if (pin !== last) begin
			edges <= edges + 1;
		end
	end
endmodule

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the carrier/interval timer block
// Assumes: Byte bus, one access per cycle, inputs driven at falling edges
// Notes:   Register contents are modelled in an associative array
`timescale 1ns/1ps
module tb_top;
	logic        ref_clk = 0;        // System clock, 200 MHz
	logic        reset = 1;          // Synchronous reset
	logic        clk_en = 1;         // Clock enable, low freezes the design
	logic        mem_wr = 0;         // Write strobe
	logic        mem_rd = 0;         // Read strobe
	logic        wclr = 1;           // Receiver count clear
	logic [15:0] mem_addr = 16'h0000; // Bus address
	logic [7:0]  mem_wdata = 8'h00;  // Bus write data
	logic [7:0]  mem_rdata;          // Bus read data
	logic [7:0]  port2_oe_n;         // Port buffer enables
	logic        timer_output_pin;   // Shaped output
	logic        irq_match_a;        // Timer A request
	logic        irq_match_b;        // Timer B request
	logic [7:0]  pv;                 // Random port direction
	int          edges;              // Receiver edge count
	int          bad_count = 0;      // Mismatches
	int          checks_done = 0;    // Comparisons
	int          seed = 25;          // Random seed
	int          gap;                // Measured request spacing
	int          cmpb;               // Timer B compare value
	int          model [int];        // Expected register contents
	bit          toe;                // Modelled output enable
	int          codes [5] = '{0, 1, 2, 3, 3};           // Timer A clock codes
	int          exts [5] = '{0, 0, 0, 0, 1};            // Extension bit
	int          divs [5] = '{64, 256, 16, 1024, 4096};  // Expected divisors

	// Clock is never gated here; freeze logic is left to the design
	always #2.5 ref_clk = ~ref_clk;

	cot_carrier_timer dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
		.timer_output_pin(timer_output_pin), .port2_oe_n(port2_oe_n),
		.irq_match_a(irq_match_a), .irq_match_b(irq_match_b));
	cot_pin_watch watch (.ref_clk(ref_clk), .pin(timer_output_pin), .clear(wclr), .edges(edges));

	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Byte comparison
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Count comparison
	task automatic chk_cnt(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Whole-byte write, model follows; no bit operations are ever issued
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		mem_addr = a;
		mem_wdata = d;
		mem_wr = 1;
		@(negedge ref_clk);
		mem_wr = 0;
		case (a)
			16'hff22: model[a] = d;
			16'hff6b: model[a] = d & 1;
			16'hff6a: model[a] = toe ? ((d & 6) | (model[a] & 1)) : (d & 7);
			16'hff69: toe = d[0];
			default: ;
		endcase
	endtask

	// Read and compare; active NRZ bit never reads back
	task automatic rdchk(input logic [15:0] a);
		logic [7:0] e;
		e = model.exists(a) ? 8'(model[a]) : 8'h00;
		if (a == 16'hff6a) e = e & 8'h06;
		@(negedge ref_clk);
		mem_addr = a;
		mem_rd = 1;
		@(negedge ref_clk);
		mem_rd = 0;
		chk_byte(mem_rdata, e);
	endtask

	// Cycles until the next request pulse, bounded
	task automatic wait_irq(input bit sel_a, output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while ((sel_a ? irq_match_a : irq_match_b) !== 1'b1 && n < 9000);
		if (n >= 9000) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, n, 0);
		end
	endtask

	// Expected steady pin level with remote select high
	function automatic logic [7:0] exp_level();
		int c;
		int v;
		c = model[16'hff6a];
		v = model[16'hff6b];
		return {7'h00, toe & ((c[0] & c[2]) ^ v[0])};
	endfunction

	// Main sequence
	initial begin
		model[16'hff22] = 255;
		model[16'hff6a] = 0;
		model[16'hff6b] = 0;
		repeat (16) @(negedge ref_clk);
		reset = 0;
		chk_byte(port2_oe_n, 8'hff);
		chk_byte({7'h00, timer_output_pin}, 8'h00);
		rdchk(16'hff22);
		rdchk(16'hff6a);
		rdchk(16'hff6b);
		rdchk(16'hff00);
		// Shared pin made an output, others random
		pv = 8'($random(seed));
		pv[3] = 1'b0;
		wr(16'hff22, pv);
		rdchk(16'hff22);
		chk_byte(port2_oe_n, pv);
		wr(16'hff6a, 8'h07);
		rdchk(16'hff6a);
		// Timer B interval, stopped before setup
		cmpb = ($random(seed) & 7) + 1;
		wr(16'hff69, 8'h00);
		wr(16'hff65, 8'(cmpb));
		wr(16'hff69, 8'h80);
		wait_irq(0, gap);
		wait_irq(0, gap);
		chk_cnt(gap, cmpb + 1);
		// Five frozen cycles stretch the interval; one tick passes before the freeze
		@(negedge ref_clk);
		clk_en = 0;
		repeat (5) @(negedge ref_clk);
		clk_en = 1;
		wait_irq(0, gap);
		chk_cnt(gap, cmpb);
		wr(16'hff69, 8'h00);
		// Every prescaler tap of timer A
		for (int i = 0; i < 5; i++) begin
			wr(16'hff68, 8'h00);
			wr(16'hff6d, 8'(exts[i]));
			wr(16'hff64, 8'h00);
			wr(16'hff68, 8'(8'h80 | (codes[i] << 3)));
			wait_irq(1, gap);
			wait_irq(1, gap);
			chk_cnt(gap, divs[i]);
		end
		// Timer A counting timer B matches
		wr(16'hff68, 8'h00);
		wr(16'hff65, 8'h03);
		wr(16'hff69, 8'h80);
		wr(16'hff64, 8'h01);
		wr(16'hff68, 8'ha0);
		wait_irq(1, gap);
		wait_irq(1, gap);
		chk_cnt(gap, 8);
		wr(16'hff68, 8'h00);
		wr(16'hff69, 8'h00);
		// Carrier mode with remote select high
		wr(16'hff6a, 8'h07);
		wr(16'hff69, 8'h87);
		repeat (4) @(negedge ref_clk);
		chk_byte({7'h00, timer_output_pin}, exp_level());
		wr(16'hff6b, 8'h01);
		repeat (2) @(negedge ref_clk);
		chk_byte({7'h00, timer_output_pin}, exp_level());
		wr(16'hff6b, 8'h00);
		wr(16'hff6a, 8'h04);
		repeat (3) @(negedge ref_clk);
		chk_byte({7'h00, timer_output_pin}, exp_level());
		rdchk(16'hff6a);
		// Carrier shown: one toggle every four cycles
		wr(16'hff6a, 8'h02);
		repeat (4) @(negedge ref_clk);
		wclr = 0;
		repeat (40) @(negedge ref_clk);
		chk_cnt(edges, 10);
		// Empty buffer reaches NRZ on a timer A match
		wr(16'hff6a, 8'h00);
		wr(16'hff64, 8'h00);
		wr(16'hff68, 8'ha8);
		wait_irq(1, gap);
		wait_irq(1, gap);
		chk_cnt(gap, 2 * 4);
		model[16'hff6a] = model[16'hff6a] & 6;
		repeat (4) @(negedge ref_clk);
		wclr = 1;
		@(negedge ref_clk);
		wclr = 0;
		repeat (30) @(negedge ref_clk);
		chk_cnt(edges, 0);
		chk_byte({7'h00, timer_output_pin}, 8'h00);
		// Mid-run reset must clear remote select and both NRZ bits
		wr(16'hff6a, 8'h06);
		rdchk(16'hff6a);
		reset = 1;
		repeat (2) @(negedge ref_clk);
		reset = 0;
		model[16'hff22] = 255;
		model[16'hff6a] = 0;
		model[16'hff6b] = 0;
		toe = 0;
		rdchk(16'hff6a);
		rdchk(16'hff22);
		chk_byte({7'h00, timer_output_pin}, 8'h00);
		test_done();
	end

	// Watchdog, well beyond the longest expected run
	initial begin
		#300000;
		bad_count++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 1, 0);
		test_done();
	end
endmodule
